//--- rtl/otc_pkg.sv
// Constants and types for the oscillator trim and start-up control block
// Function
// - Trim is six-bit signed, software writable, zero default
// - Zero calibrated; max positive fastest, most negative slowest
// - Trim write slews oscillator; execution continues, no flag
// - Trim bits seven and six read zero
// - Crystal modes count 1024 input oscillations before release
// - Count after power-on/power-up delay, and each wake-up
// - Core held, counter frozen during start-up count
// - External clock drives crystal input; output pin freed
// - External clock mode skips start-up count entirely
// - Fully static: stopped clock keeps all state
// - Crystal modes select low, medium, high gain
// - RC mode drives output pin with clock/4
// - RC-with-io mode frees output pin as I/O
// - Trim cleared on power-on/brown-out, else kept
// - Clock source chosen by configuration select field
package otc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W      = 2;
	localparam int          DATA_W      = 8;
	localparam logic [1:0]  TRIM_ADDR   = 2'h0;
	localparam logic [1:0]  CTRL_ADDR   = 2'h1;
	localparam logic [1:0]  STAT_ADDR   = 2'h2;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int          TRIM_W      = 6;
	localparam logic [5:0]  TRIM_RST    = 6'h00;
	localparam int          INTERNAL_FREQUENCY_SELECT_LSB    = 4;
	localparam logic [1:0]  INTERNAL_FREQUENCY_SELECT_RST    = 2'h2;
	localparam int          LOCK_BIT    = 3;
	localparam int          STABLE_BIT  = 2;
	localparam int          BUSY_BIT    = 3;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          STARTUP_COUNT  = 1024;
	localparam int          QUARTER_DIV    = 4;
	localparam int          CLK_PERIOD_PS  = 5000;
	localparam int          STEP_TIME_NS   = 1000;
	localparam int          STEP_CYCLES    = (STEP_TIME_NS * 1000) / CLK_PERIOD_PS;

	// ----------------------------------------------------------------
	// Amplifier gain codes
	// ----------------------------------------------------------------
	localparam logic [1:0]  GAIN_OFF    = 2'h0;
	localparam logic [1:0]  GAIN_LOW    = 2'h1;
	localparam logic [1:0]  GAIN_MED    = 2'h2;
	localparam logic [1:0]  GAIN_HIGH   = 2'h3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_LOW_XTAL,
		MODE_MED_XTAL,
		MODE_HIGH_XTAL,
		MODE_EXT_CLK,
		MODE_INT_IO,
		MODE_INT_QUARTER_CLOCK_OUTPUT,
		MODE_RC_IO,
		MODE_RC_QUARTER_CLOCK_OUTPUT
	} otc_mode_t;

	typedef enum logic [1:0] {
		SEQ_POWER_UP,
		SEQ_START_UP,
		SEQ_RUN
	} otc_seq_t;

	typedef enum logic {
		CNT_IDLE,
		CNT_BUSY
	} otc_cnt_t;

endpackage : otc_pkg

//--- rtl/otc_startup_counter.sv
// Start-up cycle counter that gates release after oscillator start
`timescale 1ns/10ps
module otc_startup_counter #(
	parameter int COUNT = otc_pkg::STARTUP_COUNT
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic srst_in,
	// Control
	input  wire logic start_in,
	input  wire logic osc_edge_in,
	// Status
	output logic      busy_out,
	output logic      done_out
);

	localparam int CW = $clog2(COUNT + 1);

	otc_pkg::otc_cnt_t state_q, state_d;
	logic [CW-1:0]     cnt_q, cnt_d;
	logic              done_q, done_d;

	// ----------------------------------------------------------------
	// Counting
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		done_d  = 1'b0;
		case (state_q)
			otc_pkg::CNT_IDLE: begin
				cnt_d = cnt_q;
			end
			otc_pkg::CNT_BUSY: begin
				// No edges means no progress, nothing times out
				if (osc_edge_in) begin
					cnt_d = cnt_q + CW'(1);
					if (cnt_q == CW'(COUNT - 1)) begin
						state_d = otc_pkg::CNT_IDLE;
						done_d  = 1'b1;
					end
				end
			end
			default: state_d = otc_pkg::CNT_IDLE;
		endcase
		// A new trigger always starts from scratch
		if (start_in) begin
			state_d = otc_pkg::CNT_BUSY;
			cnt_d   = '0;
			done_d  = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= otc_pkg::CNT_IDLE;
			cnt_q   <= '0;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			done_q  <= done_d;
		end
	end

	assign busy_out = (state_q == otc_pkg::CNT_BUSY);
	assign done_out = done_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	AST_RESTART: assert property (start_in |=> busy_out && cnt_q == '0)
		else $error("counter did not restart");
	AST_DONE_FULL: assert property ($rose(done_out) |-> $past(cnt_q) == CW'(COUNT - 1))
		else $error("release before full count");
	AST_FROZEN: assert property (busy_out && !osc_edge_in && !start_in |=> $stable(cnt_q))
		else $error("count moved without an edge");
	COV_DONE: cover property (busy_out ##1 done_out);

endmodule : otc_startup_counter

//--- rtl/otc_clock_divider.sv
// Divider of oscillator edge pulses into a slower square wave
`timescale 1ns/10ps
module otc_clock_divider #(
	parameter int DIV = otc_pkg::QUARTER_DIV
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic srst_in,
	// Edge enable
	input  wire logic osc_edge_in,
	// Divided clock
	output logic      div_clk_out
);

	localparam int HALF = DIV / 2;
	localparam int CW   = (HALF > 1) ? $clog2(HALF) : 1;

	logic [CW-1:0] cnt_q, cnt_d;
	logic          out_q, out_d;

	// ----------------------------------------------------------------
	// Toggle every half period of oscillator edges
	// ----------------------------------------------------------------
	always_comb begin
		cnt_d = cnt_q;
		out_d = out_q;
		if (osc_edge_in) begin
			if (cnt_q == CW'(HALF - 1)) begin
				cnt_d = '0;
				out_d = ~out_q;
			end else begin
				cnt_d = cnt_q + CW'(1);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cnt_q <= '0;
			out_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign div_clk_out = out_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	AST_TOGGLE_ON_EDGE: assert property (!osc_edge_in |=> $stable(div_clk_out))
		else $error("divided clock moved without an edge");

endmodule : otc_clock_divider

//--- rtl/otc_osc_ctrl.sv
// Oscillator trim, start-up sequencing and pin control top level
`timescale 1ns/10ps
module otc_osc_ctrl #(
	parameter int STARTUP_COUNT = otc_pkg::STARTUP_COUNT,
	parameter int STEP_CYCLES   = otc_pkg::STEP_CYCLES
) (
	// Clock and power-on reset
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	// Other reset sources and events
	input  wire logic        bor_in,
	input  wire logic        other_rst_in,
	input  wire logic        wake_in,
	input  wire logic        power_up_delay_timer_en_in,
	input  wire logic        power_up_delay_timer_done_in,
	// Configuration word select field
	input  wire logic [2:0]  mode_cfg_in,
	// Register port
	input  wire logic [1:0]  addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [7:0]  rdata_out,
	// Internal oscillator status and controls
	input  wire logic        int_locked_in,
	input  wire logic        int_stable_in,
	output logic      [5:0]  trim_value_out,
	output logic      [1:0]  int_freq_sel_out,
	// Crystal input activity, one pulse per oscillation
	input  wire logic        osc_edge_in,
	// Core control
	output logic             core_hold_out,
	output logic      [1:0]  amp_gain_out,
	output logic             cin_gpio_out,
	// Crystal output pin
	input  wire logic        cout_in,
	output logic             cout_out,
	output logic             cout_oe_out,
	output logic             cout_gpio_rd_out,
	// Port logic for the crystal output pin as I/O
	input  wire logic        gpio_out_in,
	input  wire logic        gpio_oe_in
);

	otc_pkg::otc_mode_t mode;
	otc_pkg::otc_seq_t  seq_q, seq_d;
	logic        is_xtal, is_pin_io, is_quarter;
	logic [5:0]  trim_q, trim_d;
	logic [5:0]  applied_q, applied_d;
	logic [1:0]  internal_frequency_select_q, internal_frequency_select_d;
	logic [7:0]  rdata_q, rdata_d;
	logic [$clog2(STEP_CYCLES)-1:0] tick_q, tick_d;
	logic        step_en;
	logic        start_req;
	logic        cnt_busy, cnt_done;
	logic        quarter_clk;

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	assign mode       = otc_pkg::otc_mode_t'(mode_cfg_in);
	assign is_xtal    = (mode == otc_pkg::MODE_LOW_XTAL) || (mode == otc_pkg::MODE_MED_XTAL)
		|| (mode == otc_pkg::MODE_HIGH_XTAL);
	assign is_quarter = (mode == otc_pkg::MODE_RC_QUARTER_CLOCK_OUTPUT) || (mode == otc_pkg::MODE_INT_QUARTER_CLOCK_OUTPUT);
	assign is_pin_io  = (mode == otc_pkg::MODE_EXT_CLK) || (mode == otc_pkg::MODE_RC_IO)
		|| (mode == otc_pkg::MODE_INT_IO);

	always_comb begin
		case (mode)
			otc_pkg::MODE_LOW_XTAL:  amp_gain_out = otc_pkg::GAIN_LOW;
			otc_pkg::MODE_MED_XTAL:  amp_gain_out = otc_pkg::GAIN_MED;
			otc_pkg::MODE_HIGH_XTAL: amp_gain_out = otc_pkg::GAIN_HIGH;
			default:                 amp_gain_out = otc_pkg::GAIN_OFF;
		endcase
	end

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	// Crystal input is only free when the internal oscillator runs the core
	assign cin_gpio_out = (mode == otc_pkg::MODE_INT_IO) || (mode == otc_pkg::MODE_INT_QUARTER_CLOCK_OUTPUT);

	always_comb begin
		if (is_quarter) begin
			cout_out    = quarter_clk;
			cout_oe_out = 1'b1;
		end else if (is_pin_io) begin
			cout_out    = gpio_out_in;
			cout_oe_out = gpio_oe_in;
		end else begin
			// Crystal modes: the amplifier owns the pin
			cout_out    = 1'b0;
			cout_oe_out = 1'b0;
		end
	end

	assign cout_gpio_rd_out = is_pin_io & cout_in;

	otc_clock_divider #(
		.DIV         (otc_pkg::QUARTER_DIV)
	) u_quarter (
		.clk_in      (clk_in),
		.srst_in     (srst_in),
		.osc_edge_in (osc_edge_in),
		.div_clk_out (quarter_clk)
	);

	// ----------------------------------------------------------------
	// Start-up sequence
	// ----------------------------------------------------------------
	always_comb begin
		seq_d     = seq_q;
		start_req = 1'b0;
		case (seq_q)
			otc_pkg::SEQ_POWER_UP: begin
				if (!power_up_delay_timer_en_in || power_up_delay_timer_done_in) begin
					if (is_xtal) begin
						start_req = 1'b1;
						seq_d     = otc_pkg::SEQ_START_UP;
					end else begin
						seq_d     = otc_pkg::SEQ_RUN;
					end
				end
			end
			otc_pkg::SEQ_START_UP: begin
				if (wake_in) begin
					start_req = 1'b1;
				end else if (cnt_done) begin
					seq_d = otc_pkg::SEQ_RUN;
				end
			end
			otc_pkg::SEQ_RUN: begin
				if (wake_in && is_xtal) begin
					start_req = 1'b1;
					seq_d     = otc_pkg::SEQ_START_UP;
				end
			end
			default: seq_d = otc_pkg::SEQ_POWER_UP;
		endcase
		if (bor_in) begin
			seq_d     = otc_pkg::SEQ_POWER_UP;
			start_req = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			seq_q <= otc_pkg::SEQ_POWER_UP;
		end else begin
			seq_q <= seq_d;
		end
	end

	// Program counter and execution stall until released
	assign core_hold_out = (seq_q != otc_pkg::SEQ_RUN);

	otc_startup_counter #(
		.COUNT       (STARTUP_COUNT)
	) u_startup (
		.clk_in      (clk_in),
		.srst_in     (srst_in),
		.start_in    (start_req),
		.osc_edge_in (osc_edge_in),
		.busy_out    (cnt_busy),
		.done_out    (cnt_done)
	);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_comb begin
		trim_d = trim_q;
		internal_frequency_select_d = internal_frequency_select_q;
		if (other_rst_in) begin
			internal_frequency_select_d = otc_pkg::INTERNAL_FREQUENCY_SELECT_RST;
		end else if (wr_in && addr_in == otc_pkg::TRIM_ADDR) begin
			trim_d = wdata_in[otc_pkg::TRIM_W-1:0];
		end else if (wr_in && addr_in == otc_pkg::CTRL_ADDR) begin
			internal_frequency_select_d = wdata_in[otc_pkg::INTERNAL_FREQUENCY_SELECT_LSB +: 2];
		end
		// Brown-out clears trim; other resets leave it alone
		if (bor_in) begin
			trim_d = otc_pkg::TRIM_RST;
			internal_frequency_select_d = otc_pkg::INTERNAL_FREQUENCY_SELECT_RST;
		end
	end

	always_comb begin
		rdata_d = '0;
		if (rd_in) begin
			if (addr_in == otc_pkg::TRIM_ADDR) begin
				rdata_d = {2'h0, trim_q};
			end else if (addr_in == otc_pkg::CTRL_ADDR) begin
				rdata_d[otc_pkg::INTERNAL_FREQUENCY_SELECT_LSB +: 2]  = internal_frequency_select_q;
				rdata_d[otc_pkg::LOCK_BIT]       = int_locked_in;
				rdata_d[otc_pkg::STABLE_BIT]     = int_stable_in;
			end else if (addr_in == otc_pkg::STAT_ADDR) begin
				rdata_d[2:0]                     = mode_cfg_in;
				rdata_d[otc_pkg::BUSY_BIT]       = cnt_busy;
			end else begin
				rdata_d = '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Trim slew: applied code steps one LSB per tick towards target
	// ----------------------------------------------------------------
	// Gradual steps avoid a frequency jump under running code
	assign step_en = (tick_q == ($clog2(STEP_CYCLES))'(STEP_CYCLES - 1));

	always_comb begin
		tick_d    = step_en ? '0 : tick_q + 1'b1;
		applied_d = applied_q;
		if (step_en) begin
			if ($signed(trim_q) > $signed(applied_q)) begin
				applied_d = applied_q + 6'h01;
			end else if ($signed(trim_q) < $signed(applied_q)) begin
				applied_d = applied_q - 6'h01;
			end
		end
		if (bor_in) begin
			applied_d = otc_pkg::TRIM_RST;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			trim_q    <= otc_pkg::TRIM_RST;
			applied_q <= otc_pkg::TRIM_RST;
			internal_frequency_select_q    <= otc_pkg::INTERNAL_FREQUENCY_SELECT_RST;
			rdata_q   <= '0;
			tick_q    <= '0;
		end else begin
			trim_q    <= trim_d;
			applied_q <= applied_d;
			internal_frequency_select_q    <= internal_frequency_select_d;
			rdata_q   <= rdata_d;
			tick_q    <= tick_d;
		end
	end

	// Signed code: zero is calibrated, 6'h1F fastest, 6'h20 slowest
	assign trim_value_out   = applied_q;
	assign int_freq_sel_out = internal_frequency_select_q;
	assign rdata_out        = rdata_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	AST_TRIM_WRITE: assert property (
		wr_in && addr_in == otc_pkg::TRIM_ADDR && !bor_in && !other_rst_in
		|=> trim_q == $past(wdata_in[5:0]))
		else $error("trim write lost");
	AST_TRIM_CLEAR: assert property (bor_in |=> trim_q == 6'h00 && applied_q == 6'h00)
		else $error("trim not cleared by brown-out");
	AST_TRIM_KEEP: assert property (other_rst_in && !bor_in |=> $stable(trim_q))
		else $error("trim changed by other reset");
	AST_UPPER_ZERO: assert property (
		rd_in && addr_in == otc_pkg::TRIM_ADDR |=> rdata_out[7:6] == 2'h0)
		else $error("trim upper bits not zero");
	AST_SLEW_STEP: assert property (
		step_en && !bor_in && applied_q != trim_q
		|=> applied_q != $past(applied_q)
		&& (($signed($past(trim_q)) > $signed($past(applied_q)))
		== ($signed(applied_q) > $signed($past(applied_q)))))
		else $error("applied trim did not step towards target");
	AST_SLEW_ONE: assert property (
		!bor_in |=> ($signed(applied_q) - $signed($past(applied_q))) inside {-1, 0, 1})
		else $error("trim slewed by more than one step");
	AST_EXT_NO_DELAY: assert property (
		seq_q == otc_pkg::SEQ_POWER_UP && mode == otc_pkg::MODE_EXT_CLK && !power_up_delay_timer_en_in
		&& !bor_in |=> !core_hold_out)
		else $error("external clock mode delayed");
	AST_XTAL_HOLD: assert property (
		start_req && !bor_in && !wake_in ##1 !bor_in && !wake_in |-> core_hold_out)
		else $error("core released during start-up");
	AST_GAIN: assert property (
		mode == otc_pkg::MODE_HIGH_XTAL |-> amp_gain_out == otc_pkg::GAIN_HIGH)
		else $error("wrong amplifier gain");
	AST_QUARTER_PIN: assert property (
		mode == otc_pkg::MODE_RC_QUARTER_CLOCK_OUTPUT |-> cout_oe_out && cout_out == quarter_clk)
		else $error("quarter clock not on pin");
	AST_PIN_IO: assert property (
		mode == otc_pkg::MODE_RC_IO |-> cout_oe_out == gpio_oe_in)
		else $error("output pin not freed");
	AST_RELEASE: assert property (
		seq_q == otc_pkg::SEQ_START_UP && $rose(cnt_done) && !wake_in && !bor_in
		|=> !core_hold_out)
		else $error("release missing after count");

	COV_XTAL_START: cover property (start_req ##[1:1000] cnt_busy);
	COV_EXT_RUN: cover property (mode == otc_pkg::MODE_EXT_CLK && !core_hold_out);
	COV_WAKE: cover property (seq_q == otc_pkg::SEQ_RUN && wake_in && is_xtal);
	COV_SLEW: cover property (step_en && applied_q != trim_q);

endmodule : otc_osc_ctrl

//--- tb/otc_xtal_model.sv
// Far-side oscillator source and crystal output pin model
`timescale 1ns/10ps
module otc_xtal_model (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic srst_in,
	// Source control
	input  wire logic run_in,
	input  wire logic slow_in,
	// Crystal output pin drive from the device
	input  wire logic cout_in,
	input  wire logic cout_oe_in,
	// Oscillation pulses and pin level
	output logic      osc_edge_out,
	output logic      pin_out
);
	logic [2:0] cnt_q;
	logic       flip_q;

	// ----------------------------------------------------------------
	// Oscillation source
	// ----------------------------------------------------------------
	// A stopped source stands still: no pulses at all, count kept
	always @(posedge clk_in) begin
		if (srst_in) begin
			cnt_q        <= 3'h0;
			osc_edge_out <= 1'b0;
			flip_q       <= 1'b0;
		end else if (run_in) begin
			flip_q       <= ~flip_q;
			cnt_q        <= (cnt_q >= (slow_in ? 3'h4 : 3'h1)) ? 3'h0 : cnt_q + 3'h1;
			osc_edge_out <= (cnt_q >= (slow_in ? 3'h4 : 3'h1));
		end else begin
			flip_q       <= ~flip_q;
			osc_edge_out <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Pin level
	// ----------------------------------------------------------------
	// Undriven pin floats, so show a level that changes every cycle
	assign pin_out = cout_oe_in ? cout_in : flip_q;
endmodule : otc_xtal_model

//--- tb/tb.sv
// Self-checking testbench for the oscillator trim and start-up block
`timescale 1ns/10ps
module tb;
	localparam int SC = 8;
	localparam int ST = 4;
	logic       clk_in = 1'b0, srst_in = 1'b1, bor_in = 1'b0, other_rst_in = 1'b0;
	logic       wake_in = 1'b0, power_up_delay_timer_en_in = 1'b0, power_up_delay_timer_done_in = 1'b0;
	logic [2:0] mode_cfg_in = 3'h1;
	logic [1:0] addr_in = 2'h0;
	logic [7:0] wdata_in = 8'h00, rdata_out;
	logic       wr_in = 1'b0, rd_in = 1'b0, int_locked_in = 1'b1, int_stable_in = 1'b0;
	logic [5:0] trim_value_out;
	logic [1:0] int_freq_sel_out, amp_gain_out;
	logic       osc_edge_in, core_hold_out, cin_gpio_out, cout_in, cout_out, cout_oe_out;
	logic       cout_gpio_rd_out, gpio_out_in = 1'b0, gpio_oe_in = 1'b0;
	logic       run_q = 1'b0, slow_q = 1'b1;
	logic       prev_pin;
	int         num_errors = 0, n_compared = 0, n, i, m;

	always #2.5 clk_in = ~clk_in;

	otc_osc_ctrl #(.STARTUP_COUNT(SC), .STEP_CYCLES(ST)) otc_osc_ctrl_inst (
		.clk_in(clk_in), .srst_in(srst_in), .bor_in(bor_in), .other_rst_in(other_rst_in),
		.wake_in(wake_in), .power_up_delay_timer_en_in(power_up_delay_timer_en_in), .power_up_delay_timer_done_in(power_up_delay_timer_done_in),
		.mode_cfg_in(mode_cfg_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .int_locked_in(int_locked_in),
		.int_stable_in(int_stable_in), .trim_value_out(trim_value_out),
		.int_freq_sel_out(int_freq_sel_out), .osc_edge_in(osc_edge_in),
		.core_hold_out(core_hold_out), .amp_gain_out(amp_gain_out),
		.cin_gpio_out(cin_gpio_out), .cout_in(cout_in), .cout_out(cout_out),
		.cout_oe_out(cout_oe_out), .cout_gpio_rd_out(cout_gpio_rd_out),
		.gpio_out_in(gpio_out_in), .gpio_oe_in(gpio_oe_in));

	otc_xtal_model otc_xtal_model_inst (
		.clk_in(clk_in), .srst_in(srst_in), .run_in(run_q), .slow_in(slow_q),
		.cout_in(cout_out), .cout_oe_in(cout_oe_out), .osc_edge_out(osc_edge_in),
		.pin_out(cout_in));

	// ----------------------------------------------------------------
	// Checking and access tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in    <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in   <= 1'b0;
		#1 chk(what, exp, rdata_out);
	endtask : rd

	// Bit 2 wake, bit 1 other reset, bit 0 brown-out
	task automatic pulse(input logic [2:0] which);
		@(posedge clk_in);
		{wake_in, other_rst_in, bor_in} <= which;
		@(posedge clk_in);
		{wake_in, other_rst_in, bor_in} <= 3'h0;
	endtask : pulse

	// Source is quiet around the wake so no edge lands on the restart edge
	task automatic wake_quiet();
		@(posedge clk_in);
		run_q <= 1'b0;
		@(posedge clk_in);
		pulse(3'h4);
		repeat (2) @(posedge clk_in);
		run_q <= 1'b1;
	endtask : wake_quiet

	// Counts source pulses taken while the core is held
	task automatic count_release(input int pause_at, output int cnt);
		int k;
		cnt = 0;
		for (k = 0; k < 3000 && core_hold_out !== 1'b0; k++) begin
			@(posedge clk_in);
			if (osc_edge_in === 1'b1 && core_hold_out === 1'b1) cnt++;
			if (cnt == pause_at) begin
				pause_at = -1;
				run_q <= 1'b0;
				repeat (40) @(posedge clk_in);
				chk("hold_stopped", 8'h01, 8'(core_hold_out));
				run_q <= 1'b1;
			end
		end
		if (core_hold_out !== 1'b0) begin
			chk("release_timeout", 8'h00, 8'(core_hold_out));
			report_and_stop();
		end
	endtask : count_release

	task automatic wait_trim(input logic [5:0] exp, input int bound);
		int k;
		for (k = 0; k < bound && trim_value_out !== exp; k++) @(posedge clk_in);
		chk("trim_applied", 8'(exp), 8'(trim_value_out));
	endtask : wait_trim

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_in);
		srst_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		run_q <= 1'b1;
		count_release(3, n);
		chk("startup_edges", 8'(SC), 8'(n));
		rd(otc_pkg::TRIM_ADDR, 8'h00, "trim_rst");
		rd(otc_pkg::CTRL_ADDR, 8'h28, "ctrl_rst");
		wr(otc_pkg::TRIM_ADDR, 8'hDF);
		#1 chk("hold_trim", 8'h00, 8'(core_hold_out));
		chk("trim_slews", 8'h01, 8'(trim_value_out !== 6'h1F));
		rd(otc_pkg::TRIM_ADDR, 8'h1F, "trim_top");
		wait_trim(6'h1F, 31 * ST + 20);
		wr(otc_pkg::TRIM_ADDR, 8'hE0);
		rd(otc_pkg::TRIM_ADDR, 8'h20, "trim_neg");
		for (i = 0; i < 4 * ST && trim_value_out === 6'h1F; i++) @(posedge clk_in);
		chk("trim_down", 8'h1E, 8'(trim_value_out));
		wait_trim(6'h20, 63 * ST + 20);
		int_locked_in <= 1'b0;
		int_stable_in <= 1'b1;
		wr(otc_pkg::CTRL_ADDR, 8'hC0);
		rd(otc_pkg::CTRL_ADDR, 8'h04, "ctrl_wr");
		chk("freq_sel_wr", 8'h00, 8'(int_freq_sel_out));
		wr(otc_pkg::STAT_ADDR, 8'hFF);
		rd(otc_pkg::STAT_ADDR, 8'h01, "stat_ro");
		rd(2'h3, 8'h00, "unmapped");
		pulse(3'h2);
		rd(otc_pkg::TRIM_ADDR, 8'h20, "trim_kept");
		rd(otc_pkg::CTRL_ADDR, 8'h24, "ctrl_other");
		chk("freq_sel_other", 8'h02, 8'(int_freq_sel_out));
		chk("hold_other", 8'h00, 8'(core_hold_out));
		@(posedge clk_in);
		run_q <= 1'b0;
		power_up_delay_timer_en_in <= 1'b1;
		pulse(3'h1);
		rd(otc_pkg::TRIM_ADDR, 8'h00, "trim_bor");
		chk("trim_out_bor", 8'h00, 8'(trim_value_out));
		repeat (20) @(posedge clk_in);
		chk("hold_power_up_delay_timer", 8'h01, 8'(core_hold_out));
		power_up_delay_timer_done_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		run_q <= 1'b1;
		count_release(-1, n);
		chk("bor_edges", 8'(SC), 8'(n));
		wake_quiet();
		rd(otc_pkg::STAT_ADDR, 8'h09, "stat_busy");
		// Let part of the count pass so a missed restart releases early
		n = 0;
		for (i = 0; i < 400 && n < 4; i++) begin
			@(posedge clk_in);
			if (osc_edge_in === 1'b1) n++;
		end
		wake_quiet();
		count_release(-1, n);
		chk("wake_edges", 8'(SC), 8'(n));
		for (m = 0; m < 8; m++) begin
			@(posedge clk_in);
			mode_cfg_in <= 3'(m);
			gpio_oe_in  <= 1'b1;
			gpio_out_in <= m[1];
			@(posedge clk_in);
			#1 chk("gain", (m < 3) ? 8'(m + 1) : 8'h00, 8'(amp_gain_out));
			chk("cin_gpio", 8'(m == 4 || m == 5), 8'(cin_gpio_out));
			if (m == 3 || m == 4 || m == 6) begin
				chk("cout_io", {6'h00, m[1], 1'b1}, {6'h00, cout_out, cout_oe_out});
				chk("cout_rd", 8'(m[1]), 8'(cout_gpio_rd_out));
			end
		end
		@(posedge clk_in);
		gpio_oe_in <= 1'b0;
		n = 0;
		@(posedge clk_in);
		prev_pin = cout_out;
		for (i = 0; i < 80; i++) begin
			@(posedge clk_in);
			if (cout_out !== prev_pin) n++;
			prev_pin = cout_out;
		end
		chk("quarter_toggles", 8'h08, 8'(n));
		chk("quarter_oe", 8'h01, 8'(cout_oe_out));
		mode_cfg_in <= 3'h3;
		run_q <= 1'b0;
		power_up_delay_timer_en_in <= 1'b0;
		pulse(3'h4);
		repeat (20) @(posedge clk_in);
		chk("ext_wake", 8'h00, 8'(core_hold_out));
		pulse(3'h1);
		repeat (4) @(posedge clk_in);
		chk("ext_bor", 8'h00, 8'(core_hold_out));
		report_and_stop();
	end
endmodule : tb
